/* dcarb_pkg.sv */
package dcarb_pkg;
	localparam logic [7:0] OFS_MAD   = 8'h00;
	localparam logic [7:0] OFS_MAA   = 8'h04;
	localparam logic [7:0] OFS_MAC   = 8'h08;
	localparam logic [7:0] OFS_ESTA  = 8'h0C;
	localparam logic [7:0] OFS_QUEUE = 8'h10;
	localparam logic [7:0] OFS_ENA0  = 8'h14;
	localparam logic [7:0] OFS_TXSEL = 8'h18;
	localparam logic [7:0] OFS_CMD   = 8'h1C;
	localparam logic [7:0] OFS_HSTA  = 8'h20;
	localparam logic [7:0] OFS_MODE  = 8'h24;
	localparam logic [7:0] MAC_WR_DATA  = 8'h48;
	localparam logic [7:0] MAC_RD_DATA  = 8'hC8;
	localparam logic [7:0] MAC_WR_BOTH  = 8'h71;
	localparam logic [3:0] CODE_64K     = 4'h1;
	localparam logic [7:0] CMD_XTF_XME  = 8'h0A;
	localparam logic [7:0] ESTA_QUEUE   = 8'h40;
	localparam logic [7:0] HSTA_TXREADY = 8'h10;
	localparam logic [7:0] MODE_RESET   = 8'h01;
	localparam int         ARB_BIT      = 2;
	localparam int         CODE_LSB     = 2;
	localparam int         NCH          = 8;
	localparam int         QDEPTH       = 4;
	localparam int         STUFF_ONES   = 5;
	localparam int         BITS_PER_FRM = 2;
	localparam int         FRAME_NS     = 125000;
	localparam int         CLK_NS       = 50;
	localparam int         FRAME_CYC    = FRAME_NS / CLK_NS;
	localparam int         SLOT_CYC     = FRAME_CYC / BITS_PER_FRM;
	typedef struct packed {
		logic [7:0] addr;
		logic [3:0] code;
	} dcarb_ci_t;
	typedef enum {ARB_FULL, ARB_EXPECT, ARB_RECEIVE, ARB_LIMITED} dcarb_state_t;
endpackage : dcarb_pkg

/* dcarb_top.sv */
// Added by the designer: the APB register port and the address map.
`timescale 1ns/1ps
module dcarb_top (
	input  wire logic                    pclk,
	input  wire logic                    presetn,
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [7:0]              paddr,
	input  wire logic [31:0]             pwdata,
	output logic      [31:0]             prdata,
	output logic                         pready,
	output logic                         pslverr,
	output logic                         irq,
	input  wire logic                    ci_strobe,
	input  wire dcarb_pkg::dcarb_ci_t    ci_in,
	output logic      [dcarb_pkg::NCH-1:0][3:0] dn_code,
	input  wire logic [dcarb_pkg::NCH-1:0]      flag_seen,
	input  wire logic                    receive_status_byte_write,
	output logic      [2:0]              rx_channel,
	output logic                         tx_go,
	output logic      [7:0]              tx_channel,
	input  wire logic                    tx_done,
	input  wire logic                    tx_bit,
	input  wire logic                    tx_valid,
	output logic                         tx_take,
	output logic                         line_tx,
	input  wire logic                    line_rx,
	output logic                         rx_bit,
	output logic                         rx_valid
);
	import dcarb_pkg::*;

	// Rotating pick: first set bit at or after the token
	function automatic logic [2:0] pick(input logic [NCH-1:0] v, input logic [2:0] tok);
		logic [2:0] r;
		logic       hit;
		logic [2:0] k;
		r = tok;
		hit = 1'b0;
		for (int i = 0; i < NCH; i++) begin
			k = tok + i[2:0];
			if (!hit && v[k]) begin
				r = k;
				hit = 1'b1;
			end
		end
		return r;
	endfunction : pick

	logic [7:0]      mad_reg, maa_reg, ena_reg, ena_prev_reg, txsel_reg, mode_reg;
	logic [7:0]      cm_data [256];
	logic [3:0]      cm_code [256];
	logic [7:0]      queue [QDEPTH];
	logic [1:0]      qwr_reg, qrd_reg;
	logic [2:0]      qcnt_reg;
	logic            txrdy_reg;
	logic [1:0]      cis_reg;
	logic            cis_prev_reg;
	dcarb_ci_t       cid1_reg, cid2_reg;
	logic [NCH-1:0]  fl1_reg, fl2_reg;
	logic [1:0]      rx_sync_reg;
	dcarb_state_t    st_reg;
	logic [NCH-1:0]  blk_reg, pend_reg, served_reg;
	logic [2:0]      grant_reg, tok_reg;
	logic [11:0]     slot_reg;
	logic [2:0]      txones_reg, rxones_reg;
	logic            wr_acc, rd_acc, setup, ci_ev, push, pop, tick;
	logic [NCH-1:0]  en_eff, req, cand, newly;
	logic [7:0]      rdata;

	assign setup  = psel & ~penable;
	assign wr_acc = psel & penable & pwrite;
	assign rd_acc = psel & penable & ~pwrite;
	assign pready = 1'b1;
	assign tick   = (slot_reg == 12'(SLOT_CYC - 1));

	// Unmapped offsets answer with an error
	always_comb begin
		case (paddr)
			OFS_MAD, OFS_MAA, OFS_MAC, OFS_ESTA, OFS_QUEUE, OFS_ENA0,
			OFS_TXSEL, OFS_CMD, OFS_HSTA, OFS_MODE: pslverr = 1'b0;
			default: pslverr = psel & penable;
		endcase
	end

	// Read mux, sampled during the setup cycle
	always_comb begin
		case (paddr)
			OFS_MAD:   rdata = mad_reg;
			OFS_MAA:   rdata = maa_reg;
			OFS_MAC:   rdata = {4'h0, cm_code[maa_reg]};
			OFS_ESTA:  rdata = (qcnt_reg != 3'h0) ? ESTA_QUEUE : 8'h00;
			OFS_QUEUE: rdata = (qcnt_reg != 3'h0) ? queue[qrd_reg] : 8'h00;
			OFS_ENA0:  rdata = ena_reg;
			OFS_TXSEL: rdata = txsel_reg;
			OFS_HSTA:  rdata = txrdy_reg ? HSTA_TXREADY : 8'h00;
			OFS_MODE:  rdata = mode_reg;
			default:   rdata = 8'h00;
		endcase
	end

	// Return word loads in read setup cycles only;
	// a write setup would otherwise pull unwritten memory codes onto the bus
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else if (setup && !pwrite) begin
			prdata <= {24'h000000, rdata};
		end
	end

	// Plain software registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			maa_reg   <= 8'h00;
			ena_reg   <= 8'h00;
			txsel_reg <= 8'h00;
			mode_reg  <= MODE_RESET;
		end else if (wr_acc) begin
			case (paddr)
				OFS_MAA:   maa_reg <= pwdata[7:0];
				OFS_ENA0:  ena_reg <= pwdata[7:0];
				OFS_TXSEL: txsel_reg <= pwdata[7:0];
				OFS_MODE:  mode_reg <= pwdata[7:0];
				default:   ;
			endcase
		end
	end

	// Staged data byte, also loaded by a fetch command
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mad_reg <= 8'h00;
		end else if (wr_acc && paddr == OFS_MAD) begin
			mad_reg <= pwdata[7:0];
		end else if (wr_acc && paddr == OFS_MAC && pwdata[7:0] == MAC_RD_DATA) begin
			mad_reg <= cm_data[maa_reg];
		end
	end

	// Connection memory: host commands, then upstream code changes
	always_ff @(posedge pclk) begin
		if (wr_acc && paddr == OFS_MAC && pwdata[7:0] == MAC_WR_DATA) begin
			cm_data[maa_reg] <= mad_reg;
		end else if (wr_acc && paddr == OFS_MAC && pwdata[7:0] == MAC_WR_BOTH) begin
			cm_data[maa_reg] <= mad_reg;
			cm_code[maa_reg] <= CODE_64K;
		end else if (push) begin
			// Upstream codes land in the signalling field only; the rest of the byte is kept
			cm_data[cid2_reg.addr][CODE_LSB+3:CODE_LSB] <= cid2_reg.code;
		end
	end

	// Line inputs pass two flip-flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cis_reg      <= 2'b00;
			cis_prev_reg <= 1'b0;
			cid1_reg     <= '0;
			cid2_reg     <= '0;
			fl1_reg      <= '0;
			fl2_reg      <= '0;
			rx_sync_reg  <= 2'b11;
		end else begin
			cis_reg      <= {cis_reg[0], ci_strobe};
			cis_prev_reg <= cis_reg[1];
			cid1_reg     <= ci_in;
			cid2_reg     <= cid1_reg;
			fl1_reg      <= flag_seen;
			fl2_reg      <= fl1_reg;
			rx_sync_reg  <= {rx_sync_reg[0], line_rx};
		end
	end

	// A rising edge of the synchronised strobe is a report; a code that differs from the stored one makes it a change event
	assign ci_ev = cis_reg[1] & ~cis_prev_reg;
	// Signalling code sits in bits 5..2 of a memory byte, next to two idle bits
	assign push  = ci_ev & (cm_data[cid2_reg.addr][CODE_LSB+3:CODE_LSB] != cid2_reg.code)
		& (qcnt_reg != 3'(QDEPTH));
	assign pop   = rd_acc & (paddr == OFS_QUEUE) & (qcnt_reg != 3'h0);
	assign irq   = (qcnt_reg != 3'h0);

	// Change queue: one entry per event holding the address
	always_ff @(posedge pclk) begin
		if (push) begin
			queue[qwr_reg] <= cid2_reg.addr;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			qwr_reg  <= 2'b00;
			qrd_reg  <= 2'b00;
			qcnt_reg <= 3'h0;
		end else begin
			if (push) qwr_reg <= qwr_reg + 2'b01;
			if (pop) qrd_reg <= qrd_reg + 2'b01;
			qcnt_reg <= qcnt_reg + 3'(push) - 3'(pop);
		end
	end

	// Transmit command and pool-ready flag; a new set beats the read clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_go      <= 1'b0;
			tx_channel <= 8'h00;
			txrdy_reg  <= 1'b0;
		end else begin
			tx_go <= wr_acc & (paddr == OFS_CMD) & (pwdata[7:0] == CMD_XTF_XME);
			if (wr_acc && paddr == OFS_CMD) tx_channel <= txsel_reg;
			if (tx_done) begin
				txrdy_reg <= 1'b1;
			end else if (rd_acc && paddr == OFS_HSTA) begin
				txrdy_reg <= 1'b0;
			end
		end
	end

	// Arbiter inputs
	assign en_eff = mode_reg[0] ? ena_reg : (ena_reg & 8'h01);
	assign req    = fl2_reg & en_eff;
	assign cand   = (pend_reg | req) & en_eff & ~served_reg;
	assign newly  = ena_reg & ~ena_prev_reg;

	// Arbiter state machine
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg     <= ARB_FULL;
			blk_reg    <= '0;
			pend_reg   <= '0;
			served_reg <= '0;
			grant_reg  <= 3'h0;
			tok_reg    <= 3'h0;
			ena_prev_reg <= 8'h00;
		end else begin
			ena_prev_reg <= ena_reg;
			pend_reg <= (pend_reg | req) & en_eff;
			case (st_reg)
				ARB_FULL: begin
					blk_reg    <= '0;
					served_reg <= '0;
					if (req != '0) begin
						grant_reg <= pick(req, tok_reg);
						blk_reg   <= en_eff & ~(8'h01 << pick(req, tok_reg));
						st_reg    <= ARB_EXPECT;
					end
				end
				ARB_EXPECT: st_reg <= ARB_RECEIVE;
				ARB_RECEIVE: begin
					blk_reg <= en_eff & ~(8'h01 << grant_reg) & ~newly;
					if (receive_status_byte_write) begin
						served_reg <= served_reg | (8'h01 << grant_reg);
						pend_reg   <= (pend_reg | req) & en_eff & ~(8'h01 << grant_reg);
						tok_reg    <= grant_reg + 3'h1;
						blk_reg    <= en_eff & ~newly;
						st_reg     <= ARB_LIMITED;
					end
				end
				ARB_LIMITED: begin
					if (cand != '0) begin
						grant_reg <= pick(cand, tok_reg);
						blk_reg   <= en_eff & ~(8'h01 << pick(cand, tok_reg));
						st_reg    <= ARB_EXPECT;
					end else begin
						blk_reg <= '0;
						st_reg  <= ARB_FULL;
					end
				end
				default: st_reg <= ARB_FULL;
			endcase
		end
	end
	assign rx_channel = grant_reg;

	// Downstream codes: channels set in en_eff carry the arbiter bit, others memory
	generate
		for (genvar c = 0; c < NCH; c++) begin : g_dn
			logic [7:0] a;
			assign a = 8'(8'h08 + 16 * c);
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					dn_code[c] <= 4'h0;
				end else if (en_eff[c]) begin
					dn_code[c] <= {cm_data[a][CODE_LSB+3], blk_reg[c] & ~newly[c],
						cm_data[a][CODE_LSB+1:CODE_LSB]};
				end else begin
					dn_code[c] <= cm_data[a][CODE_LSB+3:CODE_LSB];
				end
			end
		end
	endgenerate

	// Bit slot timer, two slots per frame
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			slot_reg <= 12'h000;
		end else begin
			slot_reg <= tick ? 12'h000 : slot_reg + 12'h001;
		end
	end

	// Transmit side stuffing: a zero follows five ones
	assign tx_take = tick & tx_valid & (txones_reg != 3'(STUFF_ONES));
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			line_tx    <= 1'b1;
			txones_reg <= 3'h0;
		end else if (tick) begin
			if (txones_reg == 3'(STUFF_ONES)) begin
				line_tx    <= 1'b0;
				txones_reg <= 3'h0;
			end else if (tx_valid) begin
				line_tx    <= tx_bit;
				txones_reg <= tx_bit ? txones_reg + 3'h1 : 3'h0;
			end else begin
				line_tx    <= 1'b1;
				txones_reg <= 3'h0;
			end
		end
	end

	// Receive side: drop the zero after five ones
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_bit     <= 1'b1;
			rx_valid   <= 1'b0;
			rxones_reg <= 3'h0;
		end else begin
			rx_valid <= 1'b0;
			if (tick) begin
				if (rx_sync_reg[1]) begin
					rx_bit     <= 1'b1;
					rx_valid   <= 1'b1;
					rxones_reg <= (rxones_reg == 3'h7) ? 3'h7 : rxones_reg + 3'h1;
				end else begin
					rx_bit     <= 1'b0;
					rx_valid   <= (rxones_reg != 3'(STUFF_ONES));
					rxones_reg <= 3'h0;
				end
			end
		end
	end
endmodule : dcarb_top

/* dcarb_chk.sv */
`timescale 1ns/1ps
module dcarb_chk
	import dcarb_pkg::*;
(
	input wire logic                   pclk,
	input wire logic                   presetn,
	input wire logic                   psel,
	input wire logic                   penable,
	input wire logic                   pwrite,
	input wire logic [7:0]             paddr,
	input wire logic [31:0]            pwdata,
	input wire logic                   pslverr,
	input wire logic                   irq,
	input wire logic [NCH-1:0][3:0]    dn_code,
	input wire logic [2:0]             rx_channel,
	input wire logic                   tx_go,
	input wire logic [7:0]             tx_channel,
	input wire logic                   line_tx
);
	logic [7:0] sel_q, mad_q, maa_q, ena_q;
	logic       up, seen;
	int         gap;
	wire        wr = psel && penable && pwrite;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Shadow copies of written registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{sel_q, mad_q, maa_q, ena_q} <= '0;
			up <= 1'b0;
		end else begin
			up <= 1'b1;
			if (wr && paddr == OFS_TXSEL) sel_q <= pwdata[7:0];
			if (wr && paddr == OFS_MAD) mad_q <= pwdata[7:0];
			if (wr && paddr == OFS_MAA) maa_q <= pwdata[7:0];
			if (wr && paddr == OFS_ENA0) ena_q <= pwdata[7:0];
		end
	end
	// Cycles since the line bit last changed
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gap <= 0;
			seen <= 1'b0;
		end else if ($changed(line_tx)) begin
			gap <= 0;
			seen <= 1'b1;
		end else gap <= gap + 1;
	end
	a_refuse_unmapped: assert property (psel && penable |-> pslverr == (paddr > OFS_MODE || paddr[1:0] != 2'b00))
		else $error("pslverr does not match offset");
	a_cmd_go: assert property (wr && paddr == OFS_CMD && pwdata[7:0] == CMD_XTF_XME |=> tx_go)
		else $error("no transmit start after command");
	a_go_pulse: assert property (tx_go |=> !tx_go)
		else $error("transmit start longer than one cycle");
	a_sel_copy: assert property (wr && paddr == OFS_CMD |=> tx_channel == sel_q)
		else $error("transmit channel not the selected one");
	a_mem_mirror: assert property (wr && paddr == OFS_MAC && pwdata[7:0] == MAC_WR_DATA && maa_q == 8'h08
		&& !ena_q[0] |-> ##[1:2] dn_code[0] == mad_q[CODE_LSB+3:CODE_LSB])
		else $error("downstream code not from stored data");
	a_avail_enable: assert property (wr && paddr == OFS_ENA0 && pwdata[1] && !ena_q[1]
		|-> ##2 !dn_code[1][ARB_BIT])
		else $error("enabled channel not available");
	a_grant_enabled: assert property ($changed(rx_channel) |-> ena_q[rx_channel])
		else $error("disabled channel granted");
	a_reset_quiet: assert property (!up |-> !irq && rx_channel == 3'h0)
		else $error("not idle after reset");
	a_slot_rate: assert property ($changed(line_tx) && seen |-> gap % SLOT_CYC == SLOT_CYC - 1)
		else $error("line bit off the slot grid");
	c_go: cover property (tx_go);
	c_grant: cover property ($changed(rx_channel));
	c_irq: cover property ($rose(irq));
endmodule : dcarb_chk
bind dcarb_top dcarb_chk chk_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pslverr,
	.irq, .dn_code, .rx_channel, .tx_go, .tx_channel, .line_tx);

/* dcarb_line_model.sv */
`timescale 1ns/1ps
module dcarb_line_model
	import dcarb_pkg::*;
(
	input  wire logic pclk,
	input  wire logic line_tx,
	output logic      line_rx,
	output dcarb_ci_t ci_in,
	output logic      ci_strobe
);
	// Transceiver loops the D-channel back
	assign line_rx = line_tx;
	initial begin
		ci_strobe = 1'b0;
		ci_in = '0;
	end
	// One upstream code report, prompt or slow
	task automatic send_ci(input logic [7:0] a, input logic [3:0] c, input int wait_cyc);
		@(posedge pclk);
		ci_in <= '{addr: a, code: c};
		repeat (wait_cyc) @(posedge pclk);
		ci_strobe <= 1'b1;
		repeat (4) @(posedge pclk);
		ci_strobe <= 1'b0;
		ci_in <= ~ci_in;
	endtask : send_ci
endmodule : dcarb_line_model

/* testbench.sv */
`timescale 1ns/1ps
module testbench;
	import dcarb_pkg::*;
	logic                pclk, presetn, psel, penable, pwrite, ci_strobe, pready, pslverr, irq;
	logic                receive_status_byte_write, tx_go, tx_done, tx_bit, tx_valid, tx_take, line_tx, line_rx;
	logic                rx_bit, rx_valid;
	logic [7:0]          paddr, tx_channel, exq[$];
	logic [31:0]         pwdata, prdata;
	logic [NCH-1:0]      flag_seen;
	logic [NCH-1:0][3:0] dn_code;
	logic [2:0]          rx_channel;
	dcarb_ci_t           ci_in;
	logic [31:0]         lfsr = 32'hA24C97FD;
	int                  n_fail = 0, cmp_count = 0, cyc = 0, first, ntx = 0, rx_cnt = 0;
	logic                txq[$];
	logic                rx_armed = 1'b0;
	localparam int       TIMEOUT_CYC = 30000;
	dcarb_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .irq, .ci_strobe, .ci_in, .dn_code, .flag_seen, .receive_status_byte_write, .rx_channel, .tx_go,
		.tx_channel, .tx_done, .tx_bit, .tx_valid, .tx_take, .line_tx, .line_rx, .rx_bit, .rx_valid);
	dcarb_line_model line_u (.pclk, .line_tx, .line_rx, .ci_in, .ci_strobe);
	// Clock
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr_next
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic finish_test;
		$display("compares=%0d mismatches=%0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : finish_test
	// One APB transfer; reads note their expected byte
	task automatic apb(input logic w, input logic [7:0] a, d, e);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h000000, d};
		if (!w) exq.push_back(e);
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	// Read results against the oldest note; timeout; bit source noting each bit sent
	// Bits: a zero, six ones to force a stuffed zero, a zero, then random bits
	always @(posedge pclk) begin
		if (psel && penable && pready && !pwrite) chk(prdata[7:0], exq.pop_front());
		if (!presetn) begin
			tx_bit <= 1'b0;
		end else if (tx_take) begin
			txq.push_back(tx_bit);
			ntx <= ntx + 1;
			tx_bit <= (ntx < 7) ? (ntx < 6) : lfsr[ntx[4:0]];
		end
		cyc++;
		if (cyc == TIMEOUT_CYC) begin
			n_fail++;
			finish_test();
		end
	end
	// Delivered line bits against the oldest bit sent; the first slot still carries idle line
	always @(posedge pclk) begin
		if (rx_valid && txq.size() > 0) begin
			if (rx_armed) begin
				chk({7'h0, rx_bit}, {7'h0, txq.pop_front()});
				rx_cnt++;
			end
			rx_armed = 1'b1;
		end
	end
	// Main sequence
	initial begin
		{presetn, psel, penable, pwrite, receive_status_byte_write, tx_done, tx_valid} = '0;
		paddr = '0;
		pwdata = '0;
		flag_seen = '0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(0, OFS_ESTA, 0, 8'h00);
		apb(0, OFS_ENA0, 0, 8'h00);
		apb(0, OFS_MODE, 0, MODE_RESET);
		apb(0, 8'h28, 0, 8'h00);
		$display("reset test done");
		for (int i = 0; i < 4; i++) begin
			lfsr = lfsr_next(lfsr);
			apb(1, OFS_MAD, lfsr[7:0], 0);
			apb(1, OFS_MAA, 8'h30 + 8'(i * 16), 0);
			apb(1, OFS_MAC, i[0] ? MAC_WR_BOTH : MAC_WR_DATA, 0);
			apb(1, OFS_MAC, MAC_RD_DATA, 0);
			apb(0, OFS_MAD, 0, lfsr[7:0]);
			if (i[0]) apb(0, OFS_MAC, 0, {4'h0, CODE_64K});
		end
		for (int c = 0; c < 3; c++) begin
			apb(1, OFS_MAD, 8'hF3, 0);
			apb(1, OFS_MAA, 8'h08 + 8'(c * 16), 0);
			apb(1, OFS_MAC, MAC_WR_DATA, 0);
		end
		repeat (2) @(posedge pclk);
		chk({4'h0, dn_code[0]}, 8'h0C);
		apb(1, OFS_ENA0, 8'h03, 0);
		repeat (2) @(posedge pclk);
		chk({4'h0, dn_code[0]}, 8'h08);
		chk({4'h0, dn_code[1]}, 8'h08);
		chk({4'h0, dn_code[2]}, 8'h0C);
		apb(0, OFS_ENA0, 0, 8'h03);
		apb(1, OFS_MODE, 8'h00, 0);
		@(posedge pclk);
		chk({4'h0, dn_code[1]}, 8'h0C);
		apb(1, OFS_MODE, MODE_RESET, 0);
		@(posedge pclk);
		chk({4'h0, dn_code[1]}, 8'h08);
		$display("memory test done");
		apb(1, OFS_MAD, 8'hC3, 0);
		apb(1, OFS_MAA, 8'h98, 0);
		apb(1, OFS_MAC, MAC_WR_DATA, 0);
		for (int i = 0; i < 3; i++) line_u.send_ci(8'h98, i[0] ? 4'h3 : 4'hC, i + 1);
		repeat (4) @(posedge pclk);
		chk({7'h0, irq}, 8'h01);
		apb(0, OFS_ESTA, 0, ESTA_QUEUE);
		for (int i = 0; i < 3; i++) apb(0, OFS_QUEUE, 0, 8'h98);
		chk({7'h0, irq}, 8'h00);
		apb(1, OFS_MAC, MAC_RD_DATA, 0);
		apb(0, OFS_MAD, 0, 8'hF3);
		$display("queue test done");
		tx_valid <= 1'b1;
		for (int i = 0; i < 2; i++) begin
			apb(1, OFS_TXSEL, 8'(1 - i), 0);
			apb(1, OFS_CMD, CMD_XTF_XME, 0);
			chk(tx_channel, 8'(1 - i));
		end
		while (rx_cnt < 10) @(posedge pclk);
		tx_done <= 1'b1;
		@(posedge pclk);
		tx_done <= 1'b0;
		apb(0, OFS_HSTA, 0, HSTA_TXREADY);
		apb(0, OFS_HSTA, 0, 8'h00);
		$display("transmit test done");
		flag_seen <= 8'h03;
		repeat (6) @(posedge pclk);
		flag_seen <= 8'h00;
		first = int'(rx_channel[0]);
		chk({7'h0, rx_channel[2:1] === 2'b00}, 8'h01);
		chk({7'h0, dn_code[1 - first][ARB_BIT]}, 8'h01);
		receive_status_byte_write <= 1'b1;
		@(posedge pclk);
		receive_status_byte_write <= 1'b0;
		repeat (6) @(posedge pclk);
		chk({5'h0, rx_channel}, 8'(1 - first));
		$display("arbiter test done");
		finish_test();
	end
endmodule : testbench
